// ---- rtl/fifo_channel_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none
module fifo_channel_cfg #(
    parameter int CH_INDEX = 0
) (
    // Clock and reset
    input  wire logic                               CLOCK,
    input  wire logic                               RESET_N,
    // Register port
    input  wire logic [fifo_cfg_pkg::BUS_AW-1:0]    ADDR,
    input  wire logic [fifo_cfg_pkg::DATA_W-1:0]    WR_DATA,
    input  wire logic                               WR_EN,
    input  wire logic                               RD_EN,
    output logic      [fifo_cfg_pkg::DATA_W-1:0]    RD_DATA,
    // Word events from the data path
    input  wire logic                               PUSH,
    input  wire logic                               POP,
    // Interrupt enables
    input  wire logic                               LOW_IRQ_EN,
    input  wire logic                               HIGH_IRQ_EN,
    // Channel state
    output logic                                    FLUSH,
    output logic      [fifo_cfg_pkg::OCC_W-1:0]     OCCUPANCY,
    output logic      [fifo_cfg_pkg::POS_W-1:0]     WRITE_POSITION,
    output logic      [fifo_cfg_pkg::POS_W-1:0]     READ_POSITION,
    output logic                                    LOW_REACHED,
    output logic                                    HIGH_REACHED,
    output logic                                    LOW_IRQ,
    output logic                                    HIGH_IRQ
);
    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [fifo_cfg_pkg::POS_W-1:0] next_pos(
        input logic [fifo_cfg_pkg::POS_W-1:0] pos,
        input logic [fifo_cfg_pkg::POS_W-1:0] first,
        input logic [fifo_cfg_pkg::POS_W-1:0] last
    );
        next_pos = (pos == last) ? first : pos + fifo_cfg_pkg::POS_ONE;
    endfunction

    function automatic logic [fifo_cfg_pkg::DATA_W-1:0] field_word(
        input logic [fifo_cfg_pkg::POS_W-1:0] value
    );
        field_word = {{(fifo_cfg_pkg::DATA_W-fifo_cfg_pkg::POS_W){1'b0}}, value};
    endfunction

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam int START_INT = fifo_cfg_pkg::SLICE_WORDS * CH_INDEX;
    localparam int END_INT   = fifo_cfg_pkg::SLICE_WORDS * (CH_INDEX + 1) - 1;
    localparam logic [fifo_cfg_pkg::POS_W-1:0] START_RST = START_INT[fifo_cfg_pkg::POS_W-1:0];
    localparam logic [fifo_cfg_pkg::POS_W-1:0] END_RST   = END_INT[fifo_cfg_pkg::POS_W-1:0];

    // ****************************************************************
    // State
    // ****************************************************************
    logic [fifo_cfg_pkg::POS_W-1:0]  end_r;
    logic [fifo_cfg_pkg::POS_W-1:0]  start_r;
    logic [fifo_cfg_pkg::POS_W-1:0]  high_r;
    logic [fifo_cfg_pkg::POS_W-1:0]  low_r;
    logic [fifo_cfg_pkg::OCC_W-1:0]  occ_r;
    logic [fifo_cfg_pkg::POS_W-1:0]  wpos_r;
    logic [fifo_cfg_pkg::POS_W-1:0]  rpos_r;
    logic [fifo_cfg_pkg::DATA_W-1:0] rdata_r;
    logic                            flush_r;
    logic                            low_flag_r;
    logic                            high_flag_r;
    logic                            low_irq_r;
    logic                            high_irq_r;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire sel_end    = ADDR == fifo_cfg_pkg::OFF_END;
    wire sel_start  = ADDR == fifo_cfg_pkg::OFF_START;
    wire sel_high   = ADDR == fifo_cfg_pkg::OFF_HIGH;
    wire sel_low    = ADDR == fifo_cfg_pkg::OFF_LOW;
    wire sel_status = ADDR == fifo_cfg_pkg::OFF_STATUS;

    // Only the low field is stored; reserved write bits fall away here.
    wire [fifo_cfg_pkg::POS_W-1:0] wr_field =
        WR_DATA[fifo_cfg_pkg::FIELD_LSB +: fifo_cfg_pkg::POS_W];

    wire wr_end    = WR_EN & sel_end;
    wire wr_start  = WR_EN & sel_start;
    wire wr_high   = WR_EN & sel_high;
    wire wr_low    = WR_EN & sel_low;
    wire wr_bound  = wr_end | wr_start;

    // ****************************************************************
    // Configuration next values
    // ****************************************************************
    wire [fifo_cfg_pkg::POS_W-1:0] end_nxt   = wr_end   ? wr_field : end_r;
    wire [fifo_cfg_pkg::POS_W-1:0] start_nxt = wr_start ? wr_field : start_r;
    wire [fifo_cfg_pkg::POS_W-1:0] high_nxt  = wr_high  ? wr_field : high_r;
    wire [fifo_cfg_pkg::POS_W-1:0] low_nxt   = wr_low   ? wr_field : low_r;

    // ****************************************************************
    // Occupancy and positions
    // ****************************************************************
    wire [fifo_cfg_pkg::OCC_W-1:0] size =
        {1'b0, end_r} - {1'b0, start_r} + fifo_cfg_pkg::OCC_ONE;
    wire is_empty = occ_r == fifo_cfg_pkg::OCC_RST;
    wire is_full  = occ_r == size;

    // Overflowing pushes and underflowing pops are dropped rather than corrupting the count.
    wire push_ok = PUSH & ~is_full;
    wire pop_ok  = POP & ~is_empty;

    wire [fifo_cfg_pkg::OCC_W-1:0] occ_step =
        (push_ok & ~pop_ok) ? occ_r + fifo_cfg_pkg::OCC_ONE :
        (pop_ok & ~push_ok) ? occ_r - fifo_cfg_pkg::OCC_ONE : occ_r;

    // A flush takes priority over traffic in the same cycle and restarts at the new start.
    wire [fifo_cfg_pkg::OCC_W-1:0] occ_nxt =
        wr_bound ? fifo_cfg_pkg::OCC_RST : occ_step;
    wire [fifo_cfg_pkg::POS_W-1:0] wpos_nxt =
        wr_bound ? start_nxt : (push_ok ? next_pos(wpos_r, start_r, end_r) : wpos_r);
    wire [fifo_cfg_pkg::POS_W-1:0] rpos_nxt =
        wr_bound ? start_nxt : (pop_ok ? next_pos(rpos_r, start_r, end_r) : rpos_r);

    // ****************************************************************
    // Threshold comparison
    // ****************************************************************
    fifo_cfg_pkg::thresholds_s thr;
    fifo_cfg_pkg::levels_s     lev;

    assign thr.high = high_r;
    assign thr.low  = low_r;

    watermark_compare u_compare (
        .occupancy  (occ_r),
        .thresholds (thr),
        .levels     (lev)
    );

    // Edge detection stops a level that simply stays reached from firing again.
    wire low_irq_nxt  = LOW_IRQ_EN  & lev.low_reached  & ~low_flag_r;
    wire high_irq_nxt = HIGH_IRQ_EN & lev.high_reached & ~high_flag_r;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    wire [fifo_cfg_pkg::DATA_W-1:0] status_word =
        ({{(fifo_cfg_pkg::DATA_W-fifo_cfg_pkg::OCC_W){1'b0}}, occ_r} << fifo_cfg_pkg::STAT_OCC_LSB) |
        ({{(fifo_cfg_pkg::DATA_W-1){1'b0}}, low_flag_r}  << fifo_cfg_pkg::STAT_LOW_BIT) |
        ({{(fifo_cfg_pkg::DATA_W-1){1'b0}}, high_flag_r} << fifo_cfg_pkg::STAT_HIGH_BIT);

    // Unmapped offsets read back as zero.
    wire [fifo_cfg_pkg::DATA_W-1:0] rd_mux =
        sel_end    ? field_word(end_r)   :
        sel_start  ? field_word(start_r) :
        sel_high   ? field_word(high_r)  :
        sel_low    ? field_word(low_r)   :
        sel_status ? status_word         : '0;

    wire [fifo_cfg_pkg::DATA_W-1:0] rdata_nxt = RD_EN ? rd_mux : '0;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            end_r   <= END_RST;
            start_r <= START_RST;
            high_r  <= fifo_cfg_pkg::HIGH_RST;
            low_r   <= fifo_cfg_pkg::LOW_RST;
        end else begin
            end_r   <= end_nxt;
            start_r <= start_nxt;
            high_r  <= high_nxt;
            low_r   <= low_nxt;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            occ_r  <= fifo_cfg_pkg::OCC_RST;
            wpos_r <= START_RST;
            rpos_r <= START_RST;
        end else begin
            occ_r  <= occ_nxt;
            wpos_r <= wpos_nxt;
            rpos_r <= rpos_nxt;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            rdata_r     <= '0;
            flush_r     <= 1'b0;
            low_flag_r  <= 1'b1;
            high_flag_r <= 1'b0;
            low_irq_r   <= 1'b0;
            high_irq_r  <= 1'b0;
        end else begin
            rdata_r     <= rdata_nxt;
            flush_r     <= wr_bound;
            low_flag_r  <= lev.low_reached;
            high_flag_r <= lev.high_reached;
            low_irq_r   <= low_irq_nxt;
            high_irq_r  <= high_irq_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign RD_DATA        = rdata_r;
    assign FLUSH          = flush_r;
    assign OCCUPANCY      = occ_r;
    assign WRITE_POSITION = wpos_r;
    assign READ_POSITION  = rpos_r;
    assign LOW_REACHED    = low_flag_r;
    assign HIGH_REACHED   = high_flag_r;
    assign LOW_IRQ        = low_irq_r;
    assign HIGH_IRQ       = high_irq_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    property p_flush_on_write;
        WR_EN && (sel_end || sel_start) |=> FLUSH ##1 !FLUSH || $past(wr_bound);
    endproperty
    a_flush_on_write: assert property (p_flush_on_write) else $error("boundary write gave no flush");

    property p_flush_restart;
        wr_bound |=> OCCUPANCY == '0 && WRITE_POSITION == start_r && READ_POSITION == start_r;
    endproperty
    a_flush_restart: assert property (p_flush_restart) else $error("flush did not restart channel");

    property p_reserved_zero;
        RD_EN && (sel_end || sel_start || sel_high || sel_low)
            |=> RD_DATA[fifo_cfg_pkg::DATA_W-1:fifo_cfg_pkg::POS_W] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_end_readback;
        wr_end ##1 (RD_EN && sel_end && !WR_EN)
            |=> RD_DATA[fifo_cfg_pkg::POS_W-1:0] == $past(WR_DATA[fifo_cfg_pkg::POS_W-1:0], 2);
    endproperty
    a_end_readback: assert property (p_end_readback) else $error("end boundary readback wrong");

    property p_start_to_position;
        wr_start |=> WRITE_POSITION == $past(WR_DATA[fifo_cfg_pkg::POS_W-1:0]);
    endproperty
    a_start_to_position: assert property (p_start_to_position) else $error("start not used by flush");

    property p_reset_bounds;
        $past(!RESET_N) |-> start_r == START_RST && end_r == END_RST;
    endproperty
    a_reset_bounds: assert property (p_reset_bounds) else $error("boundary reset value wrong");

    property p_reset_thresholds;
        $past(!RESET_N) |-> high_r == fifo_cfg_pkg::HIGH_RST && low_r == fifo_cfg_pkg::LOW_RST;
    endproperty
    a_reset_thresholds: assert property (p_reset_thresholds) else $error("threshold reset value wrong");

    property p_high_irq;
        HIGH_IRQ_EN && (OCCUPANCY >= {1'b0, high_r}) && !HIGH_REACHED |=> HIGH_IRQ && HIGH_REACHED;
    endproperty
    a_high_irq: assert property (p_high_irq) else $error("high threshold interrupt missing");

    property p_low_irq;
        LOW_IRQ |-> $past(LOW_IRQ_EN) && LOW_REACHED && !$past(LOW_REACHED);
    endproperty
    a_low_irq: assert property (p_low_irq) else $error("low threshold interrupt spurious");

    property p_reserved_write;
        wr_high ##1 (RD_EN && sel_high && !WR_EN)
            |=> RD_DATA == field_word($past(WR_DATA[fifo_cfg_pkg::POS_W-1:0], 2));
    endproperty
    a_reserved_write: assert property (p_reserved_write) else $error("reserved write bits stored");

    property p_end_store;
        wr_end |=> end_r == $past(WR_DATA[fifo_cfg_pkg::POS_W-1:0]);
    endproperty
    a_end_store: assert property (p_end_store) else $error("end boundary not stored");

    property p_start_store;
        wr_start |=> start_r == $past(WR_DATA[fifo_cfg_pkg::POS_W-1:0]);
    endproperty
    a_start_store: assert property (p_start_store) else $error("start boundary not stored");

    property p_high_store;
        wr_high |=> high_r == $past(WR_DATA[fifo_cfg_pkg::POS_W-1:0]);
    endproperty
    a_high_store: assert property (p_high_store) else $error("high threshold not stored");

    property p_low_store;
        wr_low |=> low_r == $past(WR_DATA[fifo_cfg_pkg::POS_W-1:0]);
    endproperty
    a_low_store: assert property (p_low_store) else $error("low threshold not stored");

    // Only a boundary write may flush, since a flush throws away every word the channel holds.
    property p_no_stray_flush;
        !wr_bound |=> !FLUSH;
    endproperty
    a_no_stray_flush: assert property (p_no_stray_flush) else $error("flush without boundary write");

    // The reached flags trail the fill level by one edge, so they are held against last cycle's count.
    property p_high_level;
        HIGH_REACHED == ($past(OCCUPANCY) >= {1'b0, $past(high_r)});
    endproperty
    a_high_level: assert property (p_high_level) else $error("high reached flag wrong");

    property p_low_level;
        LOW_REACHED == ($past(OCCUPANCY) <= {1'b0, $past(low_r)});
    endproperty
    a_low_level: assert property (p_low_level) else $error("low reached flag wrong");

    property p_low_irq_fire;
        LOW_IRQ_EN && (OCCUPANCY <= {1'b0, low_r}) && !LOW_REACHED |=> LOW_IRQ && LOW_REACHED;
    endproperty
    a_low_irq_fire: assert property (p_low_irq_fire) else $error("low threshold interrupt missing");

    property p_high_irq_spurious;
        HIGH_IRQ |-> $past(HIGH_IRQ_EN) && HIGH_REACHED && !$past(HIGH_REACHED);
    endproperty
    a_high_irq_spurious: assert property (p_high_irq_spurious) else $error("high interrupt spurious");

    c_flush:     cover property (wr_bound ##1 FLUSH);
    c_high_irq:  cover property (HIGH_IRQ);
    c_low_irq:   cover property (LOW_IRQ);
    c_full:      cover property (is_full && PUSH);
    c_wrap:      cover property (push_ok && wpos_r == end_r);
endmodule // fifo_channel_cfg
`default_nettype wire

// ---- rtl/watermark_compare.sv ----
`timescale 1ns/1ps
`default_nettype none
module watermark_compare (
    // Fill level of the channel
    input  wire logic [fifo_cfg_pkg::OCC_W-1:0] occupancy,
    // Programmed thresholds, as fill levels of the channel
    input  wire fifo_cfg_pkg::thresholds_s      thresholds,
    // Comparison result
    output var fifo_cfg_pkg::levels_s           levels
);
    // ****************************************************************
    // Compare
    // ****************************************************************
    // Thresholds are fill levels, so no start offset is applied here.
    wire [fifo_cfg_pkg::OCC_W-1:0] high_ext = {1'b0, thresholds.high};
    wire [fifo_cfg_pkg::OCC_W-1:0] low_ext  = {1'b0, thresholds.low};

    assign levels.low_reached  = occupancy <= low_ext;
    assign levels.high_reached = occupancy >= high_ext;
endmodule // watermark_compare
`default_nettype wire

// ---- shared/fifo_cfg_pkg.sv ----
`default_nettype none
package fifo_cfg_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int POS_W  = 10;
    localparam int OCC_W  = 11;
    localparam int DATA_W = 32;
    localparam int BUS_AW = 5;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [BUS_AW-1:0] OFF_END    = 5'h00;
    localparam logic [BUS_AW-1:0] OFF_START  = 5'h04;
    localparam logic [BUS_AW-1:0] OFF_HIGH   = 5'h08;
    localparam logic [BUS_AW-1:0] OFF_LOW    = 5'h0c;
    localparam logic [BUS_AW-1:0] OFF_STATUS = 5'h10;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int FIELD_LSB       = 0;
    localparam int STAT_OCC_LSB    = 0;
    localparam int STAT_LOW_BIT    = 16;
    localparam int STAT_HIGH_BIT   = 17;
    localparam int SLICE_WORDS     = 128;
    localparam logic [POS_W-1:0] HIGH_RST = 10'h060;
    localparam logic [POS_W-1:0] LOW_RST  = 10'h020;
    localparam logic [OCC_W-1:0] OCC_RST  = 11'h000;
    localparam logic [OCC_W-1:0] OCC_ONE  = 11'h001;
    localparam logic [POS_W-1:0] POS_ONE  = 10'h001;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [POS_W-1:0] high;
        logic [POS_W-1:0] low;
    } thresholds_s;

    typedef struct packed {
        logic low_reached;
        logic high_reached;
    } levels_s;
endpackage
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ****************************************************************
    // Bench signals
    // ****************************************************************
    localparam int               CH        = 2;
    localparam logic [9:0]       START_RST = 10'h100;
    localparam logic [31:0]      ALL_ONES  = 32'hffff_ffff;
    logic                        clock     = 1'b0;
    logic                        reset_n   = 1'b0;
    logic [fifo_cfg_pkg::BUS_AW-1:0] addr  = '0;
    logic [31:0]                 wr_data   = 32'h0000_0000;
    logic                        wr_en     = 1'b0;
    logic                        rd_en     = 1'b0;
    logic [31:0]                 rd_data;
    logic                        push      = 1'b0;
    logic                        pop       = 1'b0;
    logic                        low_irq_en  = 1'b1;
    logic                        high_irq_en = 1'b1;
    logic                        flush;
    logic [10:0]                 occupancy;
    logic [9:0]                  write_position;
    logic [9:0]                  read_position;
    logic                        low_reached;
    logic                        high_reached;
    logic                        low_irq;
    logic                        high_irq;
    int                          n_fail      = 0;
    int                          check_count = 0;

    always #50 clock = ~clock;

    fifo_channel_cfg #(.CH_INDEX(CH)) dut (
        .CLOCK(clock), .RESET_N(reset_n), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
        .RD_EN(rd_en), .RD_DATA(rd_data), .PUSH(push), .POP(pop), .LOW_IRQ_EN(low_irq_en),
        .HIGH_IRQ_EN(high_irq_en), .FLUSH(flush), .OCCUPANCY(occupancy),
        .WRITE_POSITION(write_position), .READ_POSITION(read_position),
        .LOW_REACHED(low_reached), .HIGH_REACHED(high_reached), .LOW_IRQ(low_irq), .HIGH_IRQ(high_irq)
    );

    // ****************************************************************
    // Access and check tasks
    // ****************************************************************
    task automatic summarize;
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Every access leaves a free cycle behind it, so a strobe is never set and cleared in one step.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
        @(negedge clock);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        chk(rd_data, exp);
    endtask

    // A write followed at once by a read of the same place, with no free cycle between.
    task automatic wr_rd(input logic [4:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
        rd_en   <= 1'b1;
        @(posedge clock);
        rd_en   <= 1'b0;
        @(negedge clock);
        chk(rd_data, exp);
    endtask

    // Holds push or pop for n edges, then lets the flags settle one more edge.
    task automatic ev(input logic p, input logic q, input int n);
        @(posedge clock);
        push <= p;
        pop  <= q;
        repeat (n) @(posedge clock);
        push <= 1'b0;
        pop  <= 1'b0;
        @(posedge clock);
        @(negedge clock);
    endtask

    task automatic pos(input logic [10:0] o, input logic [9:0] w, input logic [9:0] r);
        chk({1'b0, occupancy, write_position, read_position}, {1'b0, o, w, r});
    endtask

    task automatic flags(input logic lo, input logic hi, input logic li, input logic hq);
        chk({28'h0, low_reached, high_reached, low_irq, high_irq}, {28'h0, lo, hi, li, hq});
    endtask

    task automatic flushed(input logic [9:0] s);
        chk({31'h0, flush}, 32'h0000_0001);
        pos(11'h000, s, s);
        @(negedge clock);
        chk({31'h0, flush}, 32'h0000_0000);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        #(100 * 20000);
        n_fail++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        rd(fifo_cfg_pkg::OFF_END, 32'h0000_017f);
        rd(fifo_cfg_pkg::OFF_START, 32'h0000_0100);
        rd(fifo_cfg_pkg::OFF_HIGH, 32'h0000_0060);
        rd(fifo_cfg_pkg::OFF_LOW, 32'h0000_0020);
        rd(fifo_cfg_pkg::OFF_STATUS, 32'h0001_0000);
        rd(5'h14, 32'h0000_0000);
        pos(11'h000, START_RST, START_RST);
        // Writes to the read-only and unmapped places must leave everything alone.
        wr(fifo_cfg_pkg::OFF_STATUS, ALL_ONES);
        wr(5'h14, ALL_ONES);
        rd(fifo_cfg_pkg::OFF_STATUS, 32'h0001_0000);
        wr(fifo_cfg_pkg::OFF_HIGH, 32'hffff_fc04);
        chk({31'h0, flush}, 32'h0000_0000);
        wr(fifo_cfg_pkg::OFF_LOW, 32'hffff_fc02);
        rd(fifo_cfg_pkg::OFF_HIGH, 32'h0000_0004);
        rd(fifo_cfg_pkg::OFF_LOW, 32'h0000_0002);
        // Back-to-back write and read-back; the end write keeps the slice but still flushes.
        wr_rd(fifo_cfg_pkg::OFF_HIGH, 32'hfc00_0004, 32'h0000_0004);
        wr_rd(fifo_cfg_pkg::OFF_END, 32'hffff_fd7f, 32'h0000_017f);
        pos(11'h000, START_RST, START_RST);
        // Thresholds are approached from one word short so an off-by-one compare shows.
        ev(1'b1, 1'b0, 3);
        pos(11'h003, 10'h103, 10'h100);
        flags(1'b0, 1'b0, 1'b0, 1'b0);
        ev(1'b1, 1'b0, 1);
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        @(negedge clock);
        flags(1'b0, 1'b1, 1'b0, 1'b0);
        rd(fifo_cfg_pkg::OFF_STATUS, 32'h0002_0004);
        ev(1'b0, 1'b1, 1);
        flags(1'b0, 1'b0, 1'b0, 1'b0);
        ev(1'b0, 1'b1, 1);
        pos(11'h002, 10'h104, 10'h102);
        flags(1'b1, 1'b0, 1'b1, 1'b0);
        @(posedge clock);
        high_irq_en <= 1'b0;
        ev(1'b1, 1'b0, 2);
        flags(1'b0, 1'b1, 1'b0, 1'b0);
        // Flush by start boundary while the channel holds words.
        wr(fifo_cfg_pkg::OFF_START, 32'hffff_fd10);
        flushed(10'h110);
        rd(fifo_cfg_pkg::OFF_START, 32'h0000_0110);
        wr(fifo_cfg_pkg::OFF_HIGH, 32'h0000_0003);
        chk({31'h0, flush}, 32'h0000_0000);
        wr(fifo_cfg_pkg::OFF_START, 32'h0000_0100);
        flushed(10'h100);
        ev(1'b1, 1'b0, 2);
        wr(fifo_cfg_pkg::OFF_END, 32'h0000_0103);
        flushed(10'h100);
        rd(fifo_cfg_pkg::OFF_END, 32'h0000_0103);
        // A four-word channel: the fifth push is refused and the position wraps.
        ev(1'b1, 1'b0, 5);
        pos(11'h004, 10'h100, 10'h100);
        flags(1'b0, 1'b1, 1'b0, 1'b0);
        // With its enable low, reaching the low threshold must raise no pulse.
        @(posedge clock);
        low_irq_en <= 1'b0;
        ev(1'b0, 1'b1, 2);
        flags(1'b1, 1'b0, 1'b0, 1'b0);
        ev(1'b0, 1'b1, 3);
        pos(11'h000, 10'h100, 10'h100);
        flags(1'b1, 1'b0, 1'b0, 1'b0);
        // A second reset in mid-run must bring back every reset value.
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        rd(fifo_cfg_pkg::OFF_END, 32'h0000_017f);
        rd(fifo_cfg_pkg::OFF_HIGH, 32'h0000_0060);
        rd(fifo_cfg_pkg::OFF_LOW, 32'h0000_0020);
        pos(11'h000, START_RST, START_RST);
        flags(1'b1, 1'b0, 1'b0, 1'b0);
        summarize();
    end
endmodule // tb
`default_nettype wire
